// ==== hdl/dsrc_top.sv ====
// Overview of operation
// - Power-save standby is entered while power_save_input is low and normal operation resumes while it is high.
// - While in standby every internal register is held at zero and all drivers are off.
// - Supply-low lockout clears the internal registers and turns all drivers off exactly like standby.
// - Overheat shutdown turns all drivers off but leaves the internal registers untouched.
// - A channel reset bit changes no register; the driver stays on and its output follows channel_enable_pin.
//
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dsrc_defines.svh"

module dsrc_top #(
   parameter int NCH  = 8,
   parameter int NREG = 16,
   parameter int DW   = 8
) (
   input  wire logic                clk_i,
   input  wire logic                reset_i,
   // Pins
   input  wire logic                power_save_input_i,
   input  wire logic                supply_low_lockout_i,
   input  wire logic                overheat_shutdown_i,
   input  wire logic [NCH-1:0]      channel_enable_pin_i,
   // Decoded serial writes, same clock
   input  wire logic                ser_wr_i,
   input  wire logic [3:0]          ser_addr_i,
   input  wire logic [DW-1:0]       ser_data_i,
   output logic                     ser_ready_o,
   // Driver control
   output logic [NCH-1:0]           drv_on_o,
   output logic [NCH-1:0]           drv_out_en_o,
   output logic [NREG*DW-1:0]       sreg_o,
   // Wishbone slave
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [7:0]          wb_adr_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic [31:0]         wb_dat_i,
   output logic [31:0]              wb_dat_o,
   output logic                     wb_ack_o,
   output logic                     irq_o
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   localparam int PW = NCH + 3;
   localparam logic [7:0] WAKE_LAST = 8'(`DSRC_WAKE_CYCLES - 1);

   logic [PW-1:0] pins_sync;
   logic          power_save_input_pin;
   logic          lockout;
   logic          overheat;
   logic [NCH-1:0] en_pin;

   dsrc_sync #(
      .W (PW)
   ) u_sync (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .async_i ({channel_enable_pin_i, overheat_shutdown_i, supply_low_lockout_i, power_save_input_i}),
      .sync_o  (pins_sync)
   );

   assign power_save_input_pin = pins_sync[0];
   assign lockout  = pins_sync[1];
   assign overheat = pins_sync[2];
   assign en_pin   = pins_sync[PW-1:3];

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   logic [`DSRC_EV_W-1:0] status;
   logic [`DSRC_EV_W-1:0] irq_en;
   logic                  soft_power_save_input;
   logic [`DSRC_EV_W-1:0] events;

   // ----------------------------------------------------------------
   // Power state
   // ----------------------------------------------------------------
   dsrc_pkg::dsrc_state_t state;
   dsrc_pkg::dsrc_state_t next_state;
   logic [7:0]            wake_cnt;
   logic                  in_standby;
   logic                  clear_regs;
   logic                  prev_standby;
   logic                  prev_lockout;
   logic                  prev_overheat;

   // Soft standby lets software park the drivers without touching the pin
   assign in_standby = ~power_save_input_pin | soft_power_save_input;
   assign clear_regs = in_standby | lockout;

   always_comb begin
      next_state = state;
      case (state)
         dsrc_pkg::DSRC_ST_OFF: begin
            if (!clear_regs) begin
               next_state = dsrc_pkg::DSRC_ST_WAKE;
            end
         end
         dsrc_pkg::DSRC_ST_WAKE: begin
            if (clear_regs) begin
               next_state = dsrc_pkg::DSRC_ST_OFF;
            end else if (wake_cnt == WAKE_LAST) begin
               next_state = dsrc_pkg::DSRC_ST_RUN;
            end
         end
         dsrc_pkg::DSRC_ST_RUN: begin
            if (clear_regs) begin
               next_state = dsrc_pkg::DSRC_ST_OFF;
            end
         end
         default: begin
            next_state = dsrc_pkg::DSRC_ST_OFF;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state <= dsrc_pkg::DSRC_ST_OFF;
      end else begin
         state <= next_state;
      end
   end

   // Counts the settling time after leaving standby
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wake_cnt <= 8'h00;
      end else if (state == dsrc_pkg::DSRC_ST_WAKE) begin
         wake_cnt <= wake_cnt + 8'h01;
      end else begin
         wake_cnt <= 8'h00;
      end
   end

   assign ser_ready_o = (state == dsrc_pkg::DSRC_ST_RUN);

   // ----------------------------------------------------------------
   // Internal register file
   // ----------------------------------------------------------------
   logic [DW-1:0] sreg [NREG];
   logic          ser_accept;
   logic          ser_reject;

   // Writes during wake-up are dropped too: the serial front end may not yet be stable
   assign ser_accept = ser_wr_i & ser_ready_o & ~clear_regs;
   assign ser_reject = ser_wr_i & ~ser_accept;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         for (int i = 0; i < NREG; i++) begin
            sreg[i] <= `DSRC_RST_SREG;
         end
      end else if (clear_regs) begin
         for (int i = 0; i < NREG; i++) begin
            sreg[i] <= `DSRC_RST_SREG;
         end
      end else if (ser_accept && (32'(ser_addr_i) < NREG)) begin
         // Overheat does not block this path, contents survive it
         sreg[ser_addr_i] <= ser_data_i;
      end
   end

   always_comb begin
      for (int i = 0; i < NREG; i++) begin
         sreg_o[i*DW +: DW] = sreg[i];
      end
   end

   // ----------------------------------------------------------------
   // Driver control
   // ----------------------------------------------------------------
   logic [NCH-1:0] ch_reset;
   logic [NCH-1:0] ch_run;
   logic           drv_kill;

   assign ch_reset = NCH'(sreg[`DSRC_IDX_CH_RESET]);
   assign ch_run   = NCH'(sreg[`DSRC_IDX_CH_RUN]);
   assign drv_kill = clear_regs | overheat;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         drv_on_o     <= '0;
         drv_out_en_o <= '0;
      end else if (drv_kill) begin
         drv_on_o     <= '0;
         drv_out_en_o <= '0;
      end else begin
         // A channel in reset keeps its driver on, output follows its pin
         drv_on_o     <= ch_reset | ch_run;
         drv_out_en_o <= (ch_reset & en_pin) | (~ch_reset & ch_run);
      end
   end

   // ----------------------------------------------------------------
   // Events and interrupt
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         prev_standby  <= 1'b1;
         prev_lockout  <= 1'b0;
         prev_overheat <= 1'b0;
      end else begin
         prev_standby  <= in_standby;
         prev_lockout  <= lockout;
         prev_overheat <= overheat;
      end
   end

   always_comb begin
      events = '0;
      events[`DSRC_BIT_STANDBY]  = in_standby & ~prev_standby;
      events[`DSRC_BIT_LOCKOUT]  = lockout & ~prev_lockout;
      events[`DSRC_BIT_OVERHEAT] = overheat & ~prev_overheat;
      events[`DSRC_BIT_READY]    = (state == dsrc_pkg::DSRC_ST_WAKE) && (next_state == dsrc_pkg::DSRC_ST_RUN);
      events[`DSRC_BIT_REJECT]   = ser_reject;
   end

   // ----------------------------------------------------------------
   // Wishbone slave
   // ----------------------------------------------------------------
   logic                  wb_req;
   logic                  wb_wr;
   logic [`DSRC_EV_W-1:0] clr_mask;
   logic [31:0]           next_rdata;
   logic [7:0]            win_ofs;

   assign wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_wr    = wb_req & wb_we_i & wb_sel_i[0];
   assign clr_mask = (wb_wr && wb_adr_i == `DSRC_OFS_IRQ_CLR) ? wb_dat_i[`DSRC_EV_W-1:0] : '0;
   assign win_ofs  = wb_adr_i - `DSRC_OFS_REGWIN;

   // New events win over a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         status <= `DSRC_RST_STATUS;
      end else begin
         status <= (status & ~clr_mask) | events;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         irq_en    <= `DSRC_RST_IRQ_EN;
         soft_power_save_input <= `DSRC_RST_CTRL;
      end else if (wb_wr) begin
         if (wb_adr_i == `DSRC_OFS_IRQ_EN) begin
            irq_en <= wb_dat_i[`DSRC_EV_W-1:0];
         end
         if (wb_adr_i == `DSRC_OFS_CTRL) begin
            soft_power_save_input <= wb_dat_i[`DSRC_BIT_SOFT_POWER_SAVE_INPUT];
         end
      end
   end

   always_comb begin
      next_rdata = 32'h00000000;
      case (wb_adr_i)
         `DSRC_OFS_STATE: begin
            next_rdata[`DSRC_BIT_STANDBY]  = in_standby;
            next_rdata[`DSRC_BIT_LOCKOUT]  = lockout;
            next_rdata[`DSRC_BIT_OVERHEAT] = overheat;
            next_rdata[`DSRC_BIT_READY]    = ser_ready_o;
         end
         `DSRC_OFS_STATUS: begin
            next_rdata[`DSRC_EV_W-1:0] = status;
         end
         `DSRC_OFS_IRQ_EN: begin
            next_rdata[`DSRC_EV_W-1:0] = irq_en;
         end
         `DSRC_OFS_CTRL: begin
            next_rdata[`DSRC_BIT_SOFT_POWER_SAVE_INPUT] = soft_power_save_input;
         end
         default: begin
            if (wb_adr_i >= `DSRC_OFS_REGWIN && win_ofs[1:0] == 2'b00 && 32'(win_ofs[7:2]) < NREG) begin
               next_rdata[DW-1:0] = sreg[win_ofs[5:2]];
            end
         end
      endcase
   end

   // One wait state; unmapped addresses answer with zero
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req && !wb_we_i) begin
            wb_dat_o <= next_rdata;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(status & irq_en);
      end
   end

endmodule // dsrc_top

`default_nettype wire

// ==== hdl/dsrc_defines.svh ====
`ifndef DSRC_DEFINES_SVH
`define DSRC_DEFINES_SVH

// ----------------------------------------------------------------
// Wishbone register map (byte addresses)
// ----------------------------------------------------------------
`define DSRC_OFS_STATE     8'h00
`define DSRC_OFS_STATUS    8'h04
`define DSRC_OFS_IRQ_CLR   8'h08
`define DSRC_OFS_IRQ_EN    8'h0C
`define DSRC_OFS_CTRL      8'h10
`define DSRC_OFS_REGWIN    8'h40

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DSRC_BIT_STANDBY   0
`define DSRC_BIT_LOCKOUT   1
`define DSRC_BIT_OVERHEAT  2
`define DSRC_BIT_READY     3
`define DSRC_BIT_REJECT    4
`define DSRC_EV_W          5
`define DSRC_BIT_SOFT_POWER_SAVE_INPUT 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DSRC_RST_STATUS    5'h00
`define DSRC_RST_IRQ_EN    5'h00
`define DSRC_RST_CTRL      1'h0
`define DSRC_RST_SREG      8'h00

// ----------------------------------------------------------------
// Internal register indices
// ----------------------------------------------------------------
`define DSRC_IDX_CH_RESET  4'h0
`define DSRC_IDX_CH_RUN    4'h1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DSRC_CLK_PERIOD_NS 10
`define DSRC_WAKE_WAIT_NS  100
`define DSRC_WAKE_CYCLES   ((`DSRC_WAKE_WAIT_NS + `DSRC_CLK_PERIOD_NS - 1) / `DSRC_CLK_PERIOD_NS)

`endif

// ==== hdl/dsrc_pkg.sv ====
package dsrc_pkg;

   // Power state of the device
   typedef enum logic [1:0] {
      DSRC_ST_OFF  = 2'b00,
      DSRC_ST_WAKE = 2'b01,
      DSRC_ST_RUN  = 2'b10
   } dsrc_state_t;

endpackage

// ==== hdl/dsrc_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module dsrc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] stage1;

   // Stage one is read only by stage two
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         stage1 <= '0;
         sync_o <= '0;
      end else begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end

endmodule // dsrc_sync

`default_nettype wire

// ==== tb/dsrc_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module dsrc_chk #(parameter int NCH = 8, parameter int NREG = 16, parameter int DW = 8) (
   input wire logic               clk_i,
   input wire logic               reset_i,
   input wire logic               power_save_input_i,
   input wire logic               supply_low_lockout_i,
   input wire logic               overheat_shutdown_i,
   input wire logic [NCH-1:0]     channel_enable_pin_i,
   input wire logic               ser_wr_i,
   input wire logic               ser_ready_o,
   input wire logic [NCH-1:0]     drv_on_o,
   input wire logic [NCH-1:0]     drv_out_en_o,
   input wire logic [NREG*DW-1:0] sreg_o,
   input wire logic               wb_cyc_i,
   input wire logic               wb_stb_i,
   input wire logic               wb_ack_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   // Four samples cover the two synchroniser flops plus the output register
   sequence s_power_save_input; !power_save_input_i [*4]; endsequence
   sequence s_lock; supply_low_lockout_i [*4]; endsequence
   sequence s_hot; overheat_shutdown_i [*4]; endsequence
   sequence s_quiet;
      (ser_ready_o && !overheat_shutdown_i && $stable(channel_enable_pin_i) && $stable(sreg_o)) [*4];
   endsequence
   property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
   property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   property p_power_save_input_clr;
      s_power_save_input |=> drv_on_o == '0 && drv_out_en_o == '0 && sreg_o == '0 && !ser_ready_o;
   endproperty
   property p_lock_clr; s_lock |=> drv_on_o == '0 && drv_out_en_o == '0 && sreg_o == '0; endproperty
   property p_hot_off; s_hot |=> drv_on_o == '0 && drv_out_en_o == '0; endproperty
   property p_wake; $rose(ser_ready_o) |-> $past(power_save_input_i, 10); endproperty
   property p_refuse; !ser_ready_o ##1 (ser_wr_i && !ser_ready_o) |=> sreg_o == '0; endproperty
   property p_rst_bit;
      s_quiet |-> (drv_on_o & sreg_o[NCH-1:0]) == sreg_o[NCH-1:0]
         && ((drv_out_en_o ^ channel_enable_pin_i) & sreg_o[NCH-1:0]) == '0;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack too long");
   a_ack_next: assert property (p_ack_next) else $error("ack missing");
   a_power_save_input_clr: assert property (p_power_save_input_clr) else $error("standby not clean");
   a_lock_clr: assert property (p_lock_clr) else $error("lockout not clean");
   a_hot_off: assert property (p_hot_off) else $error("overheat drivers on");
   a_wake: assert property (p_wake) else $error("ready too early");
   a_refuse: assert property (p_refuse) else $error("write not refused");
   a_rst_bit: assert property (p_rst_bit) else $error("reset bit drive wrong");
endmodule // dsrc_chk
bind dsrc_top dsrc_chk #(.NCH(NCH), .NREG(NREG), .DW(DW)) i_dsrc_chk (.clk_i, .reset_i,
   .power_save_input_i, .supply_low_lockout_i, .overheat_shutdown_i, .channel_enable_pin_i, .ser_wr_i,
   .ser_ready_o, .drv_on_o, .drv_out_en_o, .sreg_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o);
`default_nettype wire

// ==== tb/dsrc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dsrc_host_model #(parameter int WAIT_CYC = 15) (
   input  wire logic       clk_i,
   input  wire logic       power_save_input_i,
   output logic            ser_wr_o,
   output logic [3:0]      ser_addr_o,
   output logic [7:0]      ser_data_o
);
   int unsigned awake = 0;
   initial {ser_wr_o, ser_addr_o, ser_data_o} = 13'h0000;
   // Margin above the wake time covers the pin synchronisers
   always @(posedge clk_i) awake <= power_save_input_i ? awake + 1 : 0;
   task automatic send(input logic [3:0] a, input logic [7:0] d, input logic hold_off);
      int n = 0;
      while (hold_off && awake < WAIT_CYC && n < 100) begin
         @(posedge clk_i);
         n++;
      end
      if (hold_off && awake < WAIT_CYC) tb.give_up("host wait");
      ser_wr_o <= 1'h1;
      ser_addr_o <= a;
      ser_data_o <= d;
      @(posedge clk_i);
      ser_wr_o <= 1'h0;
      // Idle lines never keep the last value
      ser_addr_o <= ~a;
      ser_data_o <= ~d;
      @(posedge clk_i);
   endtask
endmodule // dsrc_host_model
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dsrc_defines.svh"
module tb;
   logic         clk = 1'h0, reset = 1'h1, power_save_input_pin = 1'h0, lock_pin = 1'h0, hot_pin = 1'h0;
   logic         wb_cyc = 1'h0, wb_stb = 1'h0, wb_we = 1'h0;
   logic [7:0]   wb_adr = 8'h00, en_pin = 8'h00;
   logic [31:0]  wb_dw = 32'h0, wb_dr, rd;
   logic         wb_ack, irq, ser_wr, ser_ready;
   logic [3:0]   ser_addr;
   logic [7:0]   ser_data, drv_on, drv_oe;
   logic [127:0] sreg;
   int           n_mismatch = 0, n_compared = 0;
   dsrc_top i_dsrc_top (.clk_i(clk), .reset_i(reset), .power_save_input_i(power_save_input_pin),
      .supply_low_lockout_i(lock_pin), .overheat_shutdown_i(hot_pin), .channel_enable_pin_i(en_pin),
      .ser_wr_i(ser_wr), .ser_addr_i(ser_addr), .ser_data_i(ser_data), .ser_ready_o(ser_ready),
      .drv_on_o(drv_on), .drv_out_en_o(drv_oe), .sreg_o(sreg), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dw), .wb_dat_o(wb_dr),
      .wb_ack_o(wb_ack), .irq_o(irq));
   dsrc_host_model i_host (.clk_i(clk), .power_save_input_i(power_save_input_pin), .ser_wr_o(ser_wr),
      .ser_addr_o(ser_addr), .ser_data_o(ser_data));
   initial begin forever #5 clk = ~clk; end
   task automatic print_verdict;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic give_up(input string nm);
      $display("CHECK FAILED %s expected done seen timeout", nm);
      n_mismatch++;
      print_verdict();
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      wb_cyc <= 1'h1;
      wb_stb <= 1'h1;
      wb_we <= we;
      wb_adr <= a;
      wb_dw <= d;
      do begin
         @(posedge clk);
         n++;
         if (n > 20) give_up("wb");
      end while (wb_ack !== 1'h1);
      rd = wb_dr;
      wb_cyc <= 1'h0;
      wb_stb <= 1'h0;
      @(posedge clk);
   endtask
   task automatic wait_ready;
      int n = 0;
      while (ser_ready !== 1'h1) begin
         @(posedge clk);
         n++;
         if (n > 40) give_up("ready");
      end
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs;
      wb(1'h0, `DSRC_OFS_STATE, 32'h0);
      chk("state", rd, 32'h1);
      wb(1'h0, `DSRC_OFS_STATUS, 32'h0);
      chk("status", rd, 32'h0);
      wb(1'h1, `DSRC_OFS_IRQ_EN, 32'h1F);
      wb(1'h0, `DSRC_OFS_IRQ_EN, 32'h0);
      chk("irq_en", rd, 32'h1F);
      wb(1'h0, 8'h24, 32'h0);
      chk("unmapped", rd, 32'h0);
      $display("test regs done");
   endtask
   task automatic t_wake;
      power_save_input_pin <= 1'h1;
      i_host.send(4'h1, 8'hFF, 1'h0);
      wait_ready();
      chk("early", sreg[15:8], 8'h00);
      wb(1'h0, `DSRC_OFS_STATUS, 32'h0);
      chk("reject", rd & 32'h10, 32'h10);
      i_host.send(4'h1, 8'hFF, 1'h1);
      @(posedge clk);
      chk("run", drv_on, 8'hFF);
      $display("test wake done");
   endtask
   task automatic t_chan;
      en_pin <= 8'h05;
      i_host.send(4'h0, 8'h0F, 1'h1);
      i_host.send(4'h1, 8'h00, 1'h1);
      repeat (4) @(posedge clk);
      chk("rst on", drv_on, 8'h0F);
      chk("rst oe", drv_oe, 8'h05);
      chk("rst reg", sreg[7:0], 8'h0F);
      wb(1'h0, `DSRC_OFS_REGWIN, 32'h0);
      chk("rst win", rd, 32'h0F);
      $display("test channel reset done");
   endtask
   task automatic t_hot;
      wb(1'h1, `DSRC_OFS_IRQ_CLR, 32'h1F);
      wb(1'h1, `DSRC_OFS_IRQ_EN, 32'h04);
      hot_pin <= 1'h1;
      repeat (6) @(posedge clk);
      chk("hot on", drv_on | drv_oe, 8'h00);
      chk("hot reg", sreg[15:0], 16'h000F);
      chk("irq set", irq, 1'h1);
      wb(1'h1, `DSRC_OFS_IRQ_CLR, 32'h04);
      chk("irq clr", irq, 1'h0);
      wb(1'h1, `DSRC_OFS_IRQ_EN, 32'h00);
      hot_pin <= 1'h0;
      repeat (5) @(posedge clk);
      chk("hot back", drv_on, 8'h0F);
      hot_pin <= 1'h1;
      repeat (6) @(posedge clk);
      chk("irq mask", irq, 1'h0);
      hot_pin <= 1'h0;
      $display("test overheat done");
   endtask
   task automatic t_lock;
      lock_pin <= 1'h1;
      repeat (5) @(posedge clk);
      chk("lock on", drv_on | drv_oe, 8'h00);
      chk("lock reg", sreg[15:0], 16'h0000);
      i_host.send(4'h0, 8'hAA, 1'h0);
      @(posedge clk);
      chk("lock wr", sreg[7:0], 8'h00);
      wb(1'h0, `DSRC_OFS_STATUS, 32'h0);
      chk("lock ev", rd & 32'h12, 32'h12);
      lock_pin <= 1'h0;
      wait_ready();
      $display("test lockout done");
   endtask
   task automatic t_soft;
      i_host.send(4'h1, 8'h5A, 1'h1);
      wb(1'h1, `DSRC_OFS_CTRL, 32'h1);
      wb(1'h0, `DSRC_OFS_STATE, 32'h0);
      chk("soft state", rd, 32'h1);
      chk("soft drv", drv_on | drv_oe, 8'h00);
      chk("soft reg", sreg[15:8], 8'h00);
      i_host.send(4'h1, 8'hA5, 1'h0);
      @(posedge clk);
      chk("soft wr", sreg[15:8], 8'h00);
      wb(1'h1, `DSRC_OFS_CTRL, 32'h0);
      wait_ready();
      $display("test soft standby done");
   endtask
   task automatic t_power_save_input;
      wb(1'h1, `DSRC_OFS_IRQ_CLR, 32'h1F);
      i_host.send(4'h1, 8'h3C, 1'h1);
      @(posedge clk);
      chk("pre oe", drv_oe, 8'h3C);
      power_save_input_pin <= 1'h0;
      repeat (5) @(posedge clk);
      chk("power_save_input on", drv_on | drv_oe, 8'h00);
      chk("power_save_input reg", sreg[15:8], 8'h00);
      chk("power_save_input rdy", ser_ready, 1'h0);
      wb(1'h0, `DSRC_OFS_STATUS, 32'h0);
      chk("power_save_input ev", rd & 32'h01, 32'h01);
      $display("test standby done");
   endtask
   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'h0;
      repeat (3) @(posedge clk);
      t_regs();
      t_wake();
      t_chan();
      t_hot();
      t_lock();
      t_soft();
      t_power_save_input();
      print_verdict();
   end
endmodule // tb
`default_nettype wire
